// ==== rtl/ppc_pkg.sv ====
// Constants for the port pad configuration and pin interrupt block
// Overview of operation
// - Drive select bit one gives reduced drive
// - Drive select ignored on input pins
// - Pull enable bit turns pull device on
// - Pull enable ignored on output pins
// - Polarity: one pull-down rising, zero pull-up falling
// - Interrupt enable zero masks the request
// - Active edge on pin sets its flag
// - Writing one clears flag; flag shows edge
// - Request while flag and enable both set
// - Reserved location reads zero, ignores writes
// - Output pin drives second port data bit
// - Data read: register if output, else pin
// - Second port pins interrupt in either direction
// - Input register always returns buffered pin
// - Writes to input register are ignored
// - Direction bit selects input or output
// - Direction one output, zero input
package ppc_pkg;

	// Bus widths
	localparam int ADDR_W = 8;
	localparam int DATA_W = 8;

	// Register offsets, one byte each
	localparam logic [7:0] OFS_DRV_P  = 8'h00; // Drive strength select, first port
	localparam logic [7:0] OFS_PULL_P = 8'h01; // Pull enable, first port
	localparam logic [7:0] OFS_POL_P  = 8'h02; // Pull and edge polarity, first port
	localparam logic [7:0] OFS_IEN_P  = 8'h03; // Pin interrupt enable, first port
	localparam logic [7:0] OFS_IFL_P  = 8'h04; // Pin interrupt flags, first port
	localparam logic [7:0] OFS_RSVD   = 8'h05; // Reserved location
	localparam logic [7:0] OFS_DAT_J  = 8'h06; // Output data, second port
	localparam logic [7:0] OFS_LVL_J  = 8'h07; // Pin level, second port
	localparam logic [7:0] OFS_DIR_J  = 8'h08; // Direction, second port
	localparam logic [7:0] OFS_POL_J  = 8'h09; // Edge polarity, second port
	localparam logic [7:0] OFS_IEN_J  = 8'h0A; // Pin interrupt enable, second port
	localparam logic [7:0] OFS_IFL_J  = 8'h0B; // Pin interrupt flags, second port

	// Implemented bit masks
	localparam logic [7:0] MASK_P = 8'hBF; // Bits 7 and 5-0
	localparam logic [7:0] MASK_J = 8'hC7; // Bits 7-6 and 2-0

	// Reset value of every register
	localparam logic [7:0] RST_VAL = 8'h00;

	// Value of reserved and unmapped reads
	localparam logic [7:0] RD_ZERO = 8'h00;

endpackage

// ==== rtl/ppc_top.sv ====
// Port pad configuration, second port data path and pin interrupts
//
// Chosen here: the strobed register port and the register offsets.
`timescale 1ns/1ps
module ppc_top (
	input  wire logic       ref_clk,
	input  wire logic       rst_n,
	input  wire logic       clk_en,
	input  wire logic [7:0] bus_addr,
	input  wire logic [7:0] bus_wdata,
	input  wire logic       bus_wr,
	input  wire logic       bus_rd,
	output logic      [7:0] bus_rdata,
	input  wire logic [7:0] direction_first_port,
	input  wire logic [7:0] pin_p_i,
	output logic      [7:0] pad_reduce_p,
	output logic      [7:0] pad_pull_up_p,
	output logic      [7:0] pad_pull_dn_p,
	input  wire logic [7:0] pin_j_i,
	output logic      [7:0] pin_j_o,
	output logic      [7:0] pin_j_oe,
	output logic            irq
);

	// Software registers
	logic [7:0]  drv_q;      // Drive strength select, first port
	logic [7:0]  pull_q;     // Pull enable, first port
	logic [7:0]  dat_j_q;    // Output data, second port
	logic [7:0]  dir_j_q;    // Direction, second port
	logic [15:0] pol_q;      // Edge polarity, second port high byte
	logic [15:0] ien_q;      // Interrupt enable, second port high byte
	logic [15:0] ifl_q;      // Interrupt flags, second port high byte
	logic [15:0] ifl_d;      // Next flag values

	// Pin synchronisers and edge history
	logic [15:0] sync1_q;    // First stage, read only by second stage
	logic [15:0] sync2_q;    // Synchronised pin level
	logic [15:0] prev_q;     // Previous synchronised sample
	logic [15:0] edge_hit;   // Active edge seen this cycle
	logic [15:0] impl;       // Implemented bit mask per pin
	logic [7:0]  pin_j_sync; // Synchronised second port pins
	logic [15:0] ifl_keep;   // Flags that survive this cycle's clear

	// Address decode
	wire sel_drv_p  = (bus_addr == ppc_pkg::OFS_DRV_P);
	wire sel_pull_p = (bus_addr == ppc_pkg::OFS_PULL_P);
	wire sel_pol_p  = (bus_addr == ppc_pkg::OFS_POL_P);
	wire sel_ien_p  = (bus_addr == ppc_pkg::OFS_IEN_P);
	wire sel_ifl_p  = (bus_addr == ppc_pkg::OFS_IFL_P);
	wire sel_dat_j  = (bus_addr == ppc_pkg::OFS_DAT_J);
	wire sel_lvl_j  = (bus_addr == ppc_pkg::OFS_LVL_J); // Read only, no register takes its writes
	wire sel_dir_j  = (bus_addr == ppc_pkg::OFS_DIR_J);
	wire sel_pol_j  = (bus_addr == ppc_pkg::OFS_POL_J);
	wire sel_ien_j  = (bus_addr == ppc_pkg::OFS_IEN_J);
	wire sel_ifl_j  = (bus_addr == ppc_pkg::OFS_IFL_J);

	// Qualified write strobe and write data limited to implemented bits
	wire       wr_en = clk_en & bus_wr;
	wire [7:0] wd_p  = bus_wdata & ppc_pkg::MASK_P;
	wire [7:0] wd_j  = bus_wdata & ppc_pkg::MASK_J;

	// Clear masks for the flag registers, write one to clear
	wire [15:0] clr_mask = {(wr_en & sel_ifl_j) ? wd_j : 8'h00,
	                        (wr_en & sel_ifl_p) ? wd_p : 8'h00};

	// Second port data read: stored bit for outputs, pin for inputs
	wire [7:0] dat_j_rd = ((dat_j_q & dir_j_q) | (sync2_q[15:8] & ~dir_j_q))
	                      & ppc_pkg::MASK_J;

	// Read multiplexer; reserved and unmapped offsets give zero
	wire [7:0] rd_mux = ({8{sel_drv_p}}  & drv_q)
	                  | ({8{sel_pull_p}} & pull_q)
	                  | ({8{sel_pol_p}}  & pol_q[7:0])
	                  | ({8{sel_ien_p}}  & ien_q[7:0])
	                  | ({8{sel_ifl_p}}  & ifl_q[7:0])
	                  | ({8{sel_dat_j}}  & dat_j_rd)
	                  | ({8{sel_lvl_j}}  & (sync2_q[15:8] & ppc_pkg::MASK_J))
	                  | ({8{sel_dir_j}}  & dir_j_q)
	                  | ({8{sel_pol_j}}  & pol_q[15:8])
	                  | ({8{sel_ien_j}}  & ien_q[15:8])
	                  | ({8{sel_ifl_j}}  & ifl_q[15:8]);

	// Pad controls derived from registers and pin direction
	wire [7:0] reduce_d  = drv_q & direction_first_port & ppc_pkg::MASK_P;
	wire [7:0] pull_on   = pull_q & ~direction_first_port & ppc_pkg::MASK_P;
	wire [7:0] pull_up_d = pull_on & ~pol_q[7:0];
	wire [7:0] pull_dn_d = pull_on & pol_q[7:0];

	// Request level from enabled flags
	wire irq_d = |(ifl_q & ien_q);

	assign impl = {ppc_pkg::MASK_J, ppc_pkg::MASK_P};
	assign pin_j_sync = sync2_q[15:8];
	assign ifl_keep   = ifl_q & ~clr_mask;

	// Drive strength select register
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			drv_q <= ppc_pkg::RST_VAL;
		end else if (wr_en & sel_drv_p) begin
			drv_q <= wd_p;
		end
	end

	// Pull enable register
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			pull_q <= ppc_pkg::RST_VAL;
		end else if (wr_en & sel_pull_p) begin
			pull_q <= wd_p;
		end
	end

	// Polarity registers of both ports
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			pol_q <= {ppc_pkg::RST_VAL, ppc_pkg::RST_VAL};
		end else if (wr_en & sel_pol_p) begin
			pol_q[7:0] <= wd_p;
		end else if (wr_en & sel_pol_j) begin
			pol_q[15:8] <= wd_j;
		end
	end

	// Interrupt enable registers of both ports
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			ien_q <= {ppc_pkg::RST_VAL, ppc_pkg::RST_VAL};
		end else if (wr_en & sel_ien_p) begin
			ien_q[7:0] <= wd_p;
		end else if (wr_en & sel_ien_j) begin
			ien_q[15:8] <= wd_j;
		end
	end

	// Second port output data register
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			dat_j_q <= ppc_pkg::RST_VAL;
		end else if (wr_en & sel_dat_j) begin
			dat_j_q <= wd_j;
		end
	end

	// Second port direction register, one means output
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			dir_j_q <= ppc_pkg::RST_VAL;
		end else if (wr_en & sel_dir_j) begin
			dir_j_q <= wd_j;
		end
	end

	// Two-stage synchroniser plus history stage for every pin
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			sync1_q <= {ppc_pkg::RST_VAL, ppc_pkg::RST_VAL};
			sync2_q <= {ppc_pkg::RST_VAL, ppc_pkg::RST_VAL};
			prev_q  <= {ppc_pkg::RST_VAL, ppc_pkg::RST_VAL};
		end else if (clk_en) begin
			sync1_q <= {pin_j_i, pin_p_i};
			sync2_q <= sync1_q;
			prev_q  <= sync2_q;
		end
	end

	// Per-pin edge detection and sticky flag; a new edge beats a clear
	genvar gi;
	generate
		for (gi = 0; gi < 16; gi++) begin : g_pin
			// Rising edge when polarity is one, falling edge when zero
			assign edge_hit[gi] = impl[gi] & (pol_q[gi]
			                      ? (sync2_q[gi] & ~prev_q[gi])
			                      : (~sync2_q[gi] & prev_q[gi]));
			// Set wins over the write-one clear
			assign ifl_d[gi] = edge_hit[gi] | (ifl_q[gi] & ~clr_mask[gi]);
		end
	endgenerate

	// Interrupt flag registers of both ports
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			ifl_q <= {ppc_pkg::RST_VAL, ppc_pkg::RST_VAL};
		end else if (clk_en) begin
			ifl_q <= ifl_d;
		end
	end

	// Read data stands in the cycle after an enabled read strobe and holds while clk_en is low
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			bus_rdata <= ppc_pkg::RD_ZERO;
		end else if (clk_en) begin
			bus_rdata <= bus_rd ? rd_mux : ppc_pkg::RD_ZERO;
		end
	end

	// Registered pad controls of the first port
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			pad_reduce_p  <= ppc_pkg::RST_VAL;
			pad_pull_up_p <= ppc_pkg::RST_VAL;
			pad_pull_dn_p <= ppc_pkg::RST_VAL;
		end else if (clk_en) begin
			pad_reduce_p  <= reduce_d;
			pad_pull_up_p <= pull_up_d;
			pad_pull_dn_p <= pull_dn_d;
		end
	end

	// Registered second port pin drive and enable
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			pin_j_o  <= ppc_pkg::RST_VAL;
			pin_j_oe <= ppc_pkg::RST_VAL;
		end else if (clk_en) begin
			pin_j_o  <= dat_j_q & dir_j_q;
			pin_j_oe <= dir_j_q;
		end
	end

	// Registered interrupt request level
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			irq <= 1'b0;
		end else if (clk_en) begin
			irq <= irq_d;
		end
	end

	// Reduced drive follows selection only for output pins
	property p_reduce;
		@(posedge ref_clk) disable iff (!rst_n)
		clk_en |=> pad_reduce_p == ($past(drv_q) & $past(direction_first_port) & ppc_pkg::MASK_P);
	endproperty
	a_reduce: assert property (p_reduce) else $error("reduced drive mismatch");

	// Pull device active only on input pins with enable set
	property p_pull;
		@(posedge ref_clk) disable iff (!rst_n)
		clk_en |=> (pad_pull_up_p | pad_pull_dn_p) ==
		           ($past(pull_q) & ~$past(direction_first_port) & ppc_pkg::MASK_P);
	endproperty
	a_pull: assert property (p_pull) else $error("pull enable mismatch");

	// Pull-down only where polarity is one, never both pulls
	property p_pull_pol;
		@(posedge ref_clk) disable iff (!rst_n)
		((pad_pull_dn_p & ~pol_q[7:0]) == 8'h00 || $changed(pol_q))
		&& ((pad_pull_up_p & pad_pull_dn_p) == 8'h00);
	endproperty
	a_pull_pol: assert property (p_pull_pol) else $error("pull polarity mismatch");

	// Active edge sets the flag on the next enabled edge
	property p_flag_set;
		@(posedge ref_clk) disable iff (!rst_n)
		(clk_en && edge_hit != 16'h0000) |=> ((ifl_q & $past(edge_hit)) == $past(edge_hit));
	endproperty
	a_flag_set: assert property (p_flag_set) else $error("edge did not set flag");

	// Write one clears a flag when no new edge arrives
	property p_flag_clr;
		@(posedge ref_clk) disable iff (!rst_n)
		(clk_en && (clr_mask & ~edge_hit) != 16'h0000)
		|=> (ifl_q & $past(clr_mask) & ~$past(edge_hit)) == 16'h0000;
	endproperty
	a_flag_clr: assert property (p_flag_clr) else $error("flag not cleared");

	// Request follows enabled flags one cycle later
	property p_irq;
		@(posedge ref_clk) disable iff (!rst_n)
		clk_en |=> irq == |($past(ifl_q) & $past(ien_q));
	endproperty
	a_irq: assert property (p_irq) else $error("request level mismatch");

	// Reserved location reads zero
	property p_rsvd;
		@(posedge ref_clk) disable iff (!rst_n)
		(clk_en && bus_rd && bus_addr == ppc_pkg::OFS_RSVD) |=> bus_rdata == ppc_pkg::RD_ZERO;
	endproperty
	a_rsvd: assert property (p_rsvd) else $error("reserved read not zero");

	// Second port drive equals data on output pins
	property p_drive_j;
		@(posedge ref_clk) disable iff (!rst_n)
		clk_en |=> (pin_j_oe == $past(dir_j_q)) && ((pin_j_o & pin_j_oe) == ($past(dat_j_q) & pin_j_oe));
	endproperty
	a_drive_j: assert property (p_drive_j) else $error("second port drive mismatch");

	// Data read selects register or pin by direction
	property p_dat_rd;
		@(posedge ref_clk) disable iff (!rst_n)
		(clk_en && bus_rd && sel_dat_j) |=>
		bus_rdata == ((($past(dat_j_q) & $past(dir_j_q)) | ($past(pin_j_sync) & ~$past(dir_j_q)))
		              & ppc_pkg::MASK_J);
	endproperty
	a_dat_rd: assert property (p_dat_rd) else $error("data read mismatch");

	// Writes to the input register change no state
	property p_lvl_wr;
		@(posedge ref_clk) disable iff (!rst_n)
		(bus_wr && sel_lvl_j) |=> $stable(dat_j_q) && $stable(dir_j_q) && $stable(pol_q) && $stable(ien_q);
	endproperty
	a_lvl_wr: assert property (p_lvl_wr) else $error("input register write had effect");

	// Unimplemented bits stay zero
	property p_unimpl;
		@(posedge ref_clk) disable iff (!rst_n)
		((ifl_q | ien_q | pol_q) & ~impl) == 16'h0000 && drv_q[6] == 1'b0 && dir_j_q[5:3] == 3'b000;
	endproperty
	a_unimpl: assert property (p_unimpl) else $error("unimplemented bit set");

	// Read of the input register returns synchronised pins
	property p_lvl_rd;
		@(posedge ref_clk) disable iff (!rst_n)
		(clk_en && bus_rd && sel_lvl_j) |=> bus_rdata == ($past(pin_j_sync) & ppc_pkg::MASK_J);
	endproperty
	a_lvl_rd: assert property (p_lvl_rd) else $error("pin level read mismatch");

	// Read of the direction register returns the stored bits
	property p_dir_rd;
		@(posedge ref_clk) disable iff (!rst_n)
		(clk_en && bus_rd && sel_dir_j) |=> bus_rdata == $past(dir_j_q);
	endproperty
	a_dir_rd: assert property (p_dir_rd) else $error("direction read mismatch");

	// A flag only rises where an active edge was seen
	property p_flag_only_edge;
		@(posedge ref_clk) disable iff (!rst_n)
		clk_en |=> (ifl_q & ~$past(ifl_q) & ~$past(edge_hit)) == 16'h0000;
	endproperty
	a_flag_only_edge: assert property (p_flag_only_edge) else $error("flag set without edge");

	// A set flag stays set until a one is written to it
	property p_flag_hold;
		@(posedge ref_clk) disable iff (!rst_n)
		clk_en |=> (ifl_q & $past(ifl_keep)) == $past(ifl_keep);
	endproperty
	a_flag_hold: assert property (p_flag_hold) else $error("flag lost without clear");

	// Pins move one synchroniser stage per enabled edge
	property p_sync;
		@(posedge ref_clk) disable iff (!rst_n)
		clk_en |=> (sync2_q == $past(sync1_q)) && (prev_q == $past(sync2_q));
	endproperty
	a_sync: assert property (p_sync) else $error("synchroniser stage mismatch");

	// Clock enable low keeps registers, flags and outputs
	property p_freeze;
		@(posedge ref_clk) disable iff (!rst_n)
		!clk_en |=> $stable(drv_q) && $stable(dat_j_q) && $stable(ifl_q) && $stable(sync2_q)
		            && $stable(bus_rdata) && $stable(irq);
	endproperty
	a_freeze: assert property (p_freeze) else $error("state moved while frozen");

endmodule

// ==== verif/ppc_pins.sv ====
// Model of the outside world wired to both ports
`timescale 1ns/1ps
module ppc_pins (
	input  wire logic [7:0] ext_p,    // Outside levels on the first port
	input  wire logic [7:0] ext_j,    // Outside levels on undriven second port pins
	input  wire logic [7:0] short_j,  // Pins shorted to ground
	input  wire logic [7:0] pin_j_o,  // Design drive value
	input  wire logic [7:0] pin_j_oe, // Design output enable
	output logic      [7:0] pin_p_i,  // First port pin levels
	output logic      [7:0] pin_j_i   // Resolved second port pin levels
);
	// First port pins follow the outside driver
	assign pin_p_i = ext_p;
	// Driven pins show the design level; a short to ground overrides
	assign pin_j_i = ((pin_j_oe & pin_j_o) | (~pin_j_oe & ext_j)) & ~short_j;
endmodule

// ==== verif/ppc_top_tb.sv ====
// Self-checking bench for the port pad and pin interrupt block
`timescale 1ns/1ps
module ppc_top_tb;
	logic       ref_clk   = 1'b0;  // 10 MHz clock
	logic       rst_n     = 1'b0;  // Synchronous reset
	logic       clk_en    = 1'b1;  // Clock enable
	logic [7:0] bus_addr  = 8'h00; // Register offset
	logic [7:0] bus_wdata = 8'h00; // Write data
	logic       bus_wr    = 1'b0;  // Write strobe
	logic       bus_rd    = 1'b0;  // Read strobe
	logic [7:0] dir_p     = 8'h00; // First port direction
	logic [7:0] ext_p     = 8'h00; // Outside first port levels
	logic [7:0] ext_j     = 8'h00; // Outside second port levels
	logic [7:0] short_j   = 8'h00; // Shorted second port pins
	logic [7:0] bus_rdata, pin_p_i, pin_j_i, pin_j_o, pin_j_oe;
	logic [7:0] red_p, pu_p, pd_p; // Pad controls
	logic       irq;               // Interrupt level
	int         miscompares = 0;   // Mismatches
	int         cmp_count   = 0;   // Comparisons
	int         cycles      = 0;   // Timeout counter

	ppc_top dut_u (.ref_clk(ref_clk), .rst_n(rst_n), .clk_en(clk_en), .bus_addr(bus_addr),
		.bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata),
		.direction_first_port(dir_p), .pin_p_i(pin_p_i), .pad_reduce_p(red_p),
		.pad_pull_up_p(pu_p), .pad_pull_dn_p(pd_p), .pin_j_i(pin_j_i), .pin_j_o(pin_j_o),
		.pin_j_oe(pin_j_oe), .irq(irq));
	ppc_pins pins_u (.ext_p(ext_p), .ext_j(ext_j), .short_j(short_j), .pin_j_o(pin_j_o),
		.pin_j_oe(pin_j_oe), .pin_p_i(pin_p_i), .pin_j_i(pin_j_i));

	// Clock generator
	always #50 ref_clk = ~ref_clk;

	// Cuts a hung run short
	always @(posedge ref_clk) begin
		cycles++;
		if (cycles == 3000) begin
			miscompares++;
			end_of_test();
		end
	end

	// Prints the counts and the verdict
	task automatic end_of_test();
		$display("comparisons %0d mismatches %0d", cmp_count, miscompares);
		if (miscompares == 0 && cmp_count > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask

	// Compares one value
	task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			miscompares++;
			$display("mismatch %s expected %h seen %h", name, exp, seen);
		end
	endtask

	// One-cycle register write
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge ref_clk);
		bus_addr  <= a;
		bus_wdata <= d;
		bus_wr    <= 1'b1;
		@(posedge ref_clk);
		bus_wr    <= 1'b0;
	endtask

	// One-cycle read, data checked in the following cycle
	task automatic rchk(input logic [7:0] a, input logic [7:0] exp, input string name);
		@(posedge ref_clk);
		bus_addr <= a;
		bus_rd   <= 1'b1;
		@(posedge ref_clk);
		bus_rd   <= 1'b0;
		#1;
		chk(name, bus_rdata, exp);
	endtask

	// Lets outputs settle for n cycles
	task automatic tick(input int n);
		repeat (n) @(posedge ref_clk);
		#1;
	endtask

	// Main sequence
	initial begin
		repeat (8) @(posedge ref_clk);
		rst_n <= 1'b1;
		// Reset values, unmapped offset
		for (int i = 0; i < 12; i++) begin
			rchk(8'(i), 8'h00, "reset");
		end
		rchk(8'h3C, 8'h00, "unmapped");
		$display("test reset done");
		// Masks, reserved and read-only places
		for (int i = 0; i < 4; i++) begin
			wr(8'(i), 8'hFF);
			rchk(8'(i), ppc_pkg::MASK_P, "first port reg");
		end
		wr(ppc_pkg::OFS_RSVD, 8'hFF);
		rchk(ppc_pkg::OFS_RSVD, 8'h00, "reserved");
		wr(ppc_pkg::OFS_LVL_J, 8'hFF);
		rchk(ppc_pkg::OFS_LVL_J, 8'h00, "pin level write");
		wr(ppc_pkg::OFS_DIR_J, 8'hFF);
		rchk(ppc_pkg::OFS_DIR_J, ppc_pkg::MASK_J, "direction");
		wr(ppc_pkg::OFS_DIR_J, 8'h00);
		$display("test masks done");
		// Pad controls against direction and polarity
		wr(ppc_pkg::OFS_POL_P, 8'h30);
		@(posedge ref_clk);
		dir_p <= 8'h0F;
		tick(2);
		chk("reduce", red_p, 8'h0F);
		chk("pull up", pu_p, 8'h80);
		chk("pull down", pd_p, 8'h30);
		@(posedge ref_clk);
		dir_p <= 8'hFF;
		tick(2);
		chk("reduce all out", red_p, 8'hBF);
		chk("pull up all out", pu_p | pd_p, 8'h00);
		$display("test pads done");
		// Second port data path
		wr(ppc_pkg::OFS_DIR_J, 8'hC7);
		wr(ppc_pkg::OFS_DAT_J, 8'h85);
		tick(2);
		chk("drive", pin_j_o, 8'h85);
		chk("enable", pin_j_oe, 8'hC7);
		rchk(ppc_pkg::OFS_DAT_J, 8'h85, "data out");
		@(posedge ref_clk);
		short_j <= 8'h01;
		tick(3);
		rchk(ppc_pkg::OFS_LVL_J, 8'h84, "level shorted");
		rchk(ppc_pkg::OFS_DAT_J, 8'h85, "data shorted");
		@(posedge ref_clk);
		short_j <= 8'h00;
		ext_j   <= 8'h42;
		wr(ppc_pkg::OFS_DIR_J, 8'h00);
		tick(3);
		chk("enable off", pin_j_oe, 8'h00);
		rchk(ppc_pkg::OFS_DAT_J, 8'h42, "data in");
		rchk(ppc_pkg::OFS_LVL_J, 8'h42, "level in");
		$display("test second port done");
		// First port edges, masking and clearing
		wr(ppc_pkg::OFS_POL_P, 8'h01);
		wr(ppc_pkg::OFS_IEN_P, 8'h00);
		@(posedge ref_clk);
		ext_p <= 8'h47;
		tick(5);
		rchk(ppc_pkg::OFS_IFL_P, 8'h01, "rising flag");
		chk("masked irq", {7'h00, irq}, 8'h00);
		@(posedge ref_clk);
		ext_p <= 8'h04;
		tick(5);
		rchk(ppc_pkg::OFS_IFL_P, 8'h03, "falling flag");
		wr(ppc_pkg::OFS_IEN_P, 8'h01);
		tick(2);
		chk("irq on", {7'h00, irq}, 8'h01);
		wr(ppc_pkg::OFS_IFL_P, 8'h01);
		rchk(ppc_pkg::OFS_IFL_P, 8'h02, "clear one");
		tick(1);
		chk("irq masked flag", {7'h00, irq}, 8'h00);
		wr(ppc_pkg::OFS_IFL_P, 8'h02);
		rchk(ppc_pkg::OFS_IFL_P, 8'h00, "clear all");
		$display("test first port irq done");
		// Second port edge on an output pin
		wr(ppc_pkg::OFS_DAT_J, 8'h00);
		wr(ppc_pkg::OFS_POL_J, 8'h01);
		wr(ppc_pkg::OFS_IEN_J, 8'h01);
		wr(ppc_pkg::OFS_DIR_J, 8'h01);
		tick(4);
		wr(ppc_pkg::OFS_IFL_J, 8'hFF);
		rchk(ppc_pkg::OFS_IFL_J, 8'h00, "second clear");
		wr(ppc_pkg::OFS_DAT_J, 8'h01);
		tick(5);
		rchk(ppc_pkg::OFS_IFL_J, 8'h01, "output edge");
		chk("second irq", {7'h00, irq}, 8'h01);
		$display("test second port irq done");
		// Clock enable low ignores writes and keeps flags
		@(posedge ref_clk);
		clk_en <= 1'b0;
		wr(ppc_pkg::OFS_DRV_P, 8'h00);
		wr(ppc_pkg::OFS_IFL_J, 8'hFF);
		clk_en <= 1'b1;
		rchk(ppc_pkg::OFS_DRV_P, ppc_pkg::MASK_P, "frozen drive");
		rchk(ppc_pkg::OFS_IFL_J, 8'h01, "frozen flag");
		chk("frozen irq", {7'h00, irq}, 8'h01);
		$display("test clock enable done");
		// Reset in mid-run clears registers, flags and request
		@(posedge ref_clk);
		rst_n <= 1'b0;
		repeat (2) @(posedge ref_clk);
		rst_n <= 1'b1;
		rchk(ppc_pkg::OFS_DIR_J, 8'h00, "reset direction");
		rchk(ppc_pkg::OFS_IFL_J, 8'h00, "reset flag");
		chk("reset irq", {7'h00, irq}, 8'h00);
		$display("test mid-run reset done");
		end_of_test();
	end
endmodule
